// ### core/dtc_timer.sv
// two timer/counters with shared control register behind an avalon-mm slave
//Contract
// R1 - mode 0 counts 13 bits: high byte plus low five bits of low byte.
// R2 - count wrapping from all ones to zero sets that timer's overflow flag.
// R3 - timer advances only when run set and gate clear or ext pin high.
// R4 - setting the run bit leaves both count bytes untouched.
// R5 - gate bits sit at mode register bit 7 (timer 1) and bit 3 (timer 0).
// R6 - timer 1 mode 0 uses its own run, flag, bytes and pin.
// R7 - mode 1 is mode 0 with the full 16-bit count.
// R8 - mode 2 low byte counts; overflow sets flag, reloads from high byte.
// R9 - timer 1 in mode 3 holds its count as if run were cleared.
// R10 - timer 0 mode 3 low byte uses timer 0 select, gate, run, pin, flag.
// R11 - timer 0 mode 3 high byte counts machine cycles with timer 1 run and flag.
// R12 - with timer 0 split, timer 1 still runs as baud source without interrupts.
// R13 - control bits 0 and 2 choose edge or low level external interrupts.
// R14 - control bits 1 and 3 set on external edge, cleared when serviced.
// R15 - control bits 4 and 6 are software run bits of timers 0 and 1.
// R16 - control bits 5 and 7 are overflow flags, cleared on vectoring.
// R17 - two-bit mode field per timer selects modes 0 to 3 in order.
// R18 - select bit chooses machine cycles or external count input transitions.
`timescale 1ns/1ns
`include "dtc_cfg.svh"

module dtc_timer
  import dtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        extIrqPinZero,
  input  wire logic        extIrqPinOne,
  input  wire logic        cntInZero,
  input  wire logic        cntInOne,
  input  wire logic        ackTimer0,
  input  wire logic        ackTimer1,
  input  wire logic        ackExt0,
  input  wire logic        ackExt1,
  output logic             irq,
  output logic             baudTick
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  timerControlReg_q;
  logic [7:0]  timerModeReg_q;
  logic [7:0]  countLowT0_q, countHighT0_q, countLowT1_q, countHighT1_q;
  logic [7:0]  countLowT0_d, countHighT0_d, countLowT1_d, countHighT1_d;
  logic [3:0]  irqStat_q, irqEn_q;
  logic [3:0]  mcCnt_q;
  logic        mcTick;
  logic        waitReq_q;
  logic [31:0] rdData_q;
  logic        irq_q, baud_q;
  logic        cnt0Prev_q, cnt1Prev_q, ext0Prev_q, ext1Prev_q;
  logic        ovf0, ovfHi, ovf1;
  logic        ev0, ev1, evHi;
  logic        ext0Set, ext1Set;
  logic        busWr;
  logic [7:0]  wByte;
  dtc_mode_t   mode0, mode1;

  // decoded mode fields and the qualified bus write; a write with byte
  // lane 0 disabled is dropped, since every register sits in that lane
  assign mode0 = dtc_mode_t'(timerModeReg_q[`DTC_M0_LSB +: 2]); // [R17]
  assign mode1 = dtc_mode_t'(timerModeReg_q[`DTC_M1_LSB +: 2]); // [R17]
  assign busWr = write & ~waitReq_q & byteenable[0];
  assign wByte = writedata[7:0];

  // ----------------------------------------------------------------
  // machine cycle divider
  // ----------------------------------------------------------------
  // one-cycle enable every DTC_MC_DIV clocks; all counting runs on it
  // the divider runs free, so the first tick after reset is a full cycle away
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcCnt_q <= 4'h0;
    end else if (mcCnt_q == `DTC_MC_DIV - 4'h1) begin
      mcCnt_q <= 4'h0;
    end else begin
      mcCnt_q <= mcCnt_q + 4'h1;
    end
  end
  // tick fires in the last count of each machine cycle
  assign mcTick = (mcCnt_q == `DTC_MC_DIV - 4'h1);

  // ----------------------------------------------------------------
  // count events
  // ----------------------------------------------------------------
  // external count inputs are sampled once per machine cycle, so a
  // pulse narrower than one machine cycle may be missed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt0Prev_q <= 1'b0;
      cnt1Prev_q <= 1'b0;
    end else if (mcTick) begin
      cnt0Prev_q <= cntInZero;
      cnt1Prev_q <= cntInOne;
    end
  end

  // gate opens the count when the pin is high, for pulse width use
  // timer 1 stops in its own mode 3; the split high byte of timer 0
  // ignores gate and select, it always counts machine cycles
  always_comb begin
    ev0 = mcTick & timerControlReg_q[`DTC_RUN0_BIT]                        // [R3] [R15]
        & (~timerModeReg_q[`DTC_GT0_BIT] | extIrqPinZero)                  // [R3] [R5]
        & (~timerModeReg_q[`DTC_CT0_BIT] | (cnt0Prev_q & ~cntInZero));     // [R18]
    ev1 = mcTick & timerControlReg_q[`DTC_RUN1_BIT]                        // [R6] [R15]
        & (~timerModeReg_q[`DTC_GT1_BIT] | extIrqPinOne)                   // [R5] [R6]
        & (~timerModeReg_q[`DTC_CT1_BIT] | (cnt1Prev_q & ~cntInOne))       // [R18]
        & (mode1 != DTC_MSPLIT);                                           // [R9]
    evHi = mcTick & timerControlReg_q[`DTC_RUN1_BIT];                      // [R11]
  end

  // ----------------------------------------------------------------
  // timer 0 next count
  // ----------------------------------------------------------------
  // bus writes to a count byte win over counting in the same cycle
  always_comb begin
    countLowT0_d  = countLowT0_q;
    countHighT0_d = countHighT0_q;
    ovf0          = 1'b0;
    ovfHi         = 1'b0;
    case (mode0)
      DTC_M13: begin
        if (ev0) begin
          // upper three low bits are left as they are, meaningless
          {countHighT0_d, countLowT0_d[4:0]} = {countHighT0_q, countLowT0_q[4:0]} + 13'h0001; // [R1]
          ovf0 = &{countHighT0_q, countLowT0_q[4:0]};                                      // [R2]
        end
      end
      DTC_M16: begin
        if (ev0) begin
          {countHighT0_d, countLowT0_d} = {countHighT0_q, countLowT0_q} + 16'h0001; // [R7]
          ovf0 = &{countHighT0_q, countLowT0_q};                                 // [R2]
        end
      end
      DTC_M8R: begin
        if (ev0) begin
          countLowT0_d = (&countLowT0_q) ? countHighT0_q : countLowT0_q + 8'h01; // [R8]
          ovf0 = &countLowT0_q;                                                 // [R8]
        end
      end
      DTC_MSPLIT: begin
        // the high byte overflow is routed to the timer 1 flag
        // by the control register logic further down
        if (ev0) begin
          countLowT0_d = countLowT0_q + 8'h01; // [R10]
          ovf0 = &countLowT0_q;                // [R10]
        end
        if (evHi) begin
          countHighT0_d = countHighT0_q + 8'h01; // [R11]
          ovfHi = &countHighT0_q;                // [R11]
        end
      end
      default: begin
      end
    endcase
    if (busWr && address == `DTC_CLO0_OFS) begin
      countLowT0_d = wByte;
    end
    if (busWr && address == `DTC_CHI0_OFS) begin
      countHighT0_d = wByte;
    end
  end

  // ----------------------------------------------------------------
  // timer 1 next count
  // ----------------------------------------------------------------
  // no split mode here: mode 3 simply holds the count
  always_comb begin
    countLowT1_d  = countLowT1_q;
    countHighT1_d = countHighT1_q;
    ovf1          = 1'b0;
    case (mode1)
      DTC_M13: begin
        if (ev1) begin
          {countHighT1_d, countLowT1_d[4:0]} = {countHighT1_q, countLowT1_q[4:0]} + 13'h0001; // [R1] [R6]
          ovf1 = &{countHighT1_q, countLowT1_q[4:0]};                                      // [R2] [R6]
        end
      end
      DTC_M16: begin
        if (ev1) begin
          {countHighT1_d, countLowT1_d} = {countHighT1_q, countLowT1_q} + 16'h0001; // [R7]
          ovf1 = &{countHighT1_q, countLowT1_q};                                 // [R2]
        end
      end
      DTC_M8R: begin
        if (ev1) begin
          countLowT1_d = (&countLowT1_q) ? countHighT1_q : countLowT1_q + 8'h01; // [R8]
          ovf1 = &countLowT1_q;                                                 // [R8]
        end
      end
      default: begin
        // mode 3 holds the count
      end
    endcase
    if (busWr && address == `DTC_CLO1_OFS) begin
      countLowT1_d = wByte;
    end
    if (busWr && address == `DTC_CHI1_OFS) begin
      countHighT1_d = wByte;
    end
  end

  // ----------------------------------------------------------------
  // count registers
  // ----------------------------------------------------------------
  // writing the run bit touches none of these
  // a plain register stage; all next-state logic lives above
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      countLowT0_q  <= `DTC_REG_RST;
      countHighT0_q <= `DTC_REG_RST;
      countLowT1_q  <= `DTC_REG_RST;
      countHighT1_q <= `DTC_REG_RST;
    end else begin
      countLowT0_q  <= countLowT0_d;  // [R4]
      countHighT0_q <= countHighT0_d;
      countLowT1_q  <= countLowT1_d;
      countHighT1_q <= countHighT1_d;
    end
  end

  // ----------------------------------------------------------------
  // external interrupt detection
  // ----------------------------------------------------------------
  // previous levels start high, the idle level of the pins, so the
  // release of reset never looks like a falling edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext0Prev_q <= 1'b1;
      ext1Prev_q <= 1'b1;
    end else begin
      ext0Prev_q <= extIrqPinZero;
      ext1Prev_q <= extIrqPinOne;
    end
  end
  // type bit set: falling edge; clear: pin low requests
  // a level request re-sets its flag every clock while the pin stays low
  assign ext0Set = timerControlReg_q[`DTC_IT0_BIT] ? (ext0Prev_q & ~extIrqPinZero) : ~extIrqPinZero; // [R13]
  assign ext1Set = timerControlReg_q[`DTC_IT1_BIT] ? (ext1Prev_q & ~extIrqPinOne) : ~extIrqPinOne;   // [R13]

  // ----------------------------------------------------------------
  // control and mode registers
  // ----------------------------------------------------------------
  // hardware set beats software write and service acknowledge
  // later assignments win, so the set lines come last on purpose
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timerControlReg_q <= `DTC_REG_RST;
    end else begin
      if (busWr && address == `DTC_CTRL_OFS) begin
        timerControlReg_q <= wByte; // [R13] [R15]
      end
      if (ackTimer0) begin
        timerControlReg_q[`DTC_OVF0_BIT] <= 1'b0; // [R16]
      end
      if (ackTimer1) begin
        timerControlReg_q[`DTC_OVF1_BIT] <= 1'b0; // [R16]
      end
      if (ackExt0) begin
        timerControlReg_q[`DTC_IE0_BIT] <= 1'b0; // [R14]
      end
      if (ackExt1) begin
        timerControlReg_q[`DTC_IE1_BIT] <= 1'b0; // [R14]
      end
      if (ovf0) begin
        timerControlReg_q[`DTC_OVF0_BIT] <= 1'b1; // [R2] [R16]
      end
      // split timer 0 high byte owns the timer 1 flag
      if (ovfHi || (ovf1 && mode0 != DTC_MSPLIT)) begin
        timerControlReg_q[`DTC_OVF1_BIT] <= 1'b1; // [R11] [R12] [R16]
      end
      if (ext0Set) begin
        timerControlReg_q[`DTC_IE0_BIT] <= 1'b1; // [R14]
      end
      if (ext1Set) begin
        timerControlReg_q[`DTC_IE1_BIT] <= 1'b1; // [R14]
      end
    end
  end

  // mode register is written only by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timerModeReg_q <= `DTC_REG_RST;
    end else if (busWr && address == `DTC_MODE_OFS) begin
      timerModeReg_q <= wByte; // [R5] [R17]
    end
  end

  // ----------------------------------------------------------------
  // interrupt status, enable and output
  // ----------------------------------------------------------------
  // a new event in the clearing cycle stays set
  // bit order: timer 0 overflow, ext 0, timer 1 overflow, ext 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqStat_q <= 4'h0;
    end else begin
      irqStat_q <= (irqStat_q & ~((busWr && address == `DTC_ICLR_OFS) ? wByte[3:0] : 4'h0))
                 | {ext1Set, ovfHi | (ovf1 & (mode0 != DTC_MSPLIT)), ext0Set, ovf0}; // [R12]
    end
  end

  // enable register: only the four low bits exist
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqEn_q <= 4'h0;
    end else if (busWr && address == `DTC_IEN_OFS) begin
      irqEn_q <= wByte[3:0];
    end
  end

  // timer 1 overflow always feeds the baud tick, even when its flag is not set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_q  <= 1'b0;
      baud_q <= 1'b0;
    end else begin
      irq_q  <= |(irqStat_q & irqEn_q);
      baud_q <= ovf1; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait state on every access keeps read data registered
  // at the cost of one extra cycle per access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= ~((read | write) & waitReq_q);
    end
  end

  // unmapped and write-only offsets read as zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (read && waitReq_q) begin
      case (address)
        `DTC_CTRL_OFS:  rdData_q <= {24'h00_0000, timerControlReg_q};
        `DTC_MODE_OFS:  rdData_q <= {24'h00_0000, timerModeReg_q};
        `DTC_CLO0_OFS:  rdData_q <= {24'h00_0000, countLowT0_q};
        `DTC_CHI0_OFS:  rdData_q <= {24'h00_0000, countHighT0_q};
        `DTC_CLO1_OFS:  rdData_q <= {24'h00_0000, countLowT1_q};
        `DTC_CHI1_OFS:  rdData_q <= {24'h00_0000, countHighT1_q};
        `DTC_ISTAT_OFS: rdData_q <= {28'h000_0000, irqStat_q};
        `DTC_IEN_OFS:   rdData_q <= {28'h000_0000, irqEn_q};
        default:        rdData_q <= 32'h0000_0000;
      endcase
    end
  end

  // outputs are driven straight from their registers
  assign readdata    = rdData_q;
  assign waitrequest = waitReq_q;
  assign irq         = irq_q;
  assign baudTick    = baud_q;

endmodule

// ### core/dtc_cfg.svh
// register offsets, field positions, reset values and timing counts of the dual timer block
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// ----------------------------------------------------------------
// byte addresses on the register bus
// ----------------------------------------------------------------
`define DTC_CTRL_OFS   8'h88
`define DTC_MODE_OFS   8'h8C
`define DTC_CLO0_OFS   8'h90
`define DTC_CHI0_OFS   8'h94
`define DTC_CLO1_OFS   8'h98
`define DTC_CHI1_OFS   8'h9C
`define DTC_ISTAT_OFS  8'hA0
`define DTC_ICLR_OFS   8'hA4
`define DTC_IEN_OFS    8'hA8

// ----------------------------------------------------------------
// timer control register bit positions
// ----------------------------------------------------------------
`define DTC_IT0_BIT  0
`define DTC_IE0_BIT  1
`define DTC_IT1_BIT  2
`define DTC_IE1_BIT  3
`define DTC_RUN0_BIT 4
`define DTC_OVF0_BIT 5
`define DTC_RUN1_BIT 6
`define DTC_OVF1_BIT 7

// ----------------------------------------------------------------
// timer mode register fields
// ----------------------------------------------------------------
`define DTC_M0_LSB   0
`define DTC_CT0_BIT  2
`define DTC_GT0_BIT  3
`define DTC_M1_LSB   4
`define DTC_CT1_BIT  6
`define DTC_GT1_BIT  7

// ----------------------------------------------------------------
// interrupt status layout, reset values, machine cycle divider
// ----------------------------------------------------------------
`define DTC_IRQ_OVF0 0
`define DTC_IRQ_IE0  1
`define DTC_IRQ_OVF1 2
`define DTC_IRQ_IE1  3
`define DTC_REG_RST  8'h00
`define DTC_MC_DIV   4'hC

`endif

// ### core/dtc_pkg.sv
// types shared by the dual timer block
package dtc_pkg;

  // operating mode of a timer, value of its two-bit mode field
  typedef enum logic [1:0] {
    DTC_M13    = 2'b00,
    DTC_M16    = 2'b01,
    DTC_M8R    = 2'b10,
    DTC_MSPLIT = 2'b11
  } dtc_mode_t;

endpackage

// ### bench/dtc_timer_props.sv
// assertion checker for the dual timer block, bound to its top module
`timescale 1ns/1ns

module dtc_timer_props
  import dtc_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        irq,
  input wire logic        baudTick
);
  // ----------------------------------------
  // bus handshake, read data and event pins
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic mapped;
  // the clear register is write-only, so reads treat it as unmapped
  assign mapped = address inside {8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'h9C, 8'hA0, 8'hA8};
  sequence s_take;
    (read || write) && waitrequest;
  endsequence
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  a_bus_answer: assert property (s_take |=> s_answer)
    else $error("bus request not answered in one cycle");
  a_answer_cause: assert property (!waitrequest |-> $past(read || write) && $past(waitrequest))
    else $error("answer without a request");
  a_read_upper: assert property (readdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (read && waitrequest && !mapped |=> readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_read_hold: assert property (!$stable(readdata) |-> $past(read) && $past(waitrequest))
    else $error("read data changed without a read");
  a_reset_idle: assert property ($fell(sys_rst) |-> waitrequest && !irq && !baudTick)
    else $error("outputs not idle after reset");
  // overflows only happen on machine-cycle ticks, twelve clocks apart
  a_baud_spacing: assert property (baudTick |=> !baudTick [*8] ##1 !baudTick [*3])
    else $error("baud pulses closer than a machine cycle");
  a_irq_fall: assert property ($fell(irq) |-> $past(write, 2) && !$past(waitrequest, 2))
    else $error("interrupt dropped without a register write");
endmodule

bind dtc_timer dtc_timer_props i_dtc_timer_props (
  .clk         (clk),
  .sys_rst     (sys_rst),
  .address     (address),
  .read        (read),
  .write       (write),
  .readdata    (readdata),
  .waitrequest (waitrequest),
  .irq         (irq),
  .baudTick    (baudTick)
);

// ### bench/test_dtc_timer.sv
// self-checking testbench for the dual timer block
`timescale 1ns/1ns

module test_dtc_timer
  import dtc_pkg::*;
;
  typedef struct {logic [7:0] val; logic [7:0] msk;} dtc_exp_t;
  logic        clk = 1'b0;
  logic        sysRst = 1'b1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0]  byteenable = 4'h0;
  logic [1:0]  extPin = 2'b11;
  logic [1:0]  cntIn = 2'b11;
  logic [3:0]  ack = 4'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic        baudTick;
  logic [31:0] rnd;
  logic [7:0]  v;
  dtc_exp_t    expQ[$];
  int          n_errors = 0;
  int          num_checks = 0;
  int          nBaud = 0;
  int          seed = 32'h1C5C_94EE;

  dtc_timer i_dtc_timer (
    .clk           (clk),
    .sys_rst       (sysRst),
    .address       (address),
    .read          (read),
    .write         (write),
    .writedata     (writedata),
    .byteenable    (byteenable),
    .readdata      (readdata),
    .waitrequest   (waitrequest),
    .extIrqPinZero (extPin[0]),
    .extIrqPinOne  (extPin[1]),
    .cntInZero     (cntIn[0]),
    .cntInOne      (cntIn[1]),
    .ackTimer0     (ack[0]),
    .ackTimer1     (ack[1]),
    .ackExt0       (ack[2]),
    .ackExt1       (ack[3]),
    .irq           (irq),
    .baudTick      (baudTick)
  );

  // ------------------------------
  // clock, compare and bus tasks
  // ------------------------------
  always #4 clk = ~clk;

  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // bits outside the mask are left free, upper bits must read zero
  task automatic cmp_reg(input logic [31:0] got, input logic [7:0] val, input logic [7:0] msk);
    num_checks++;
    if ({got[31:8], got[7:0] & msk} !== {24'h00_0000, val & msk}) begin
      n_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, val);
    end
  endtask

  task automatic cmp_out(input logic [31:0] got, input logic [31:0] val);
    num_checks++;
    if (got !== val) begin
      n_errors++;
      $display("[FAIL] %0t output %h expected %h", $time, got, val);
    end
  endtask

  // one avalon cycle; the request is held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] be);
    int k;
    k = 0;
    rnd = $random(seed);
    @(posedge clk);
    address <= adr;
    read <= !wr;
    write <= wr;
    writedata <= {rnd[31:8], dat};
    byteenable <= be;
    do begin
      @(posedge clk);
      k++;
      if (k > 20) begin
        n_errors++;
        close_out();
      end
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    bus(1'b1, adr, dat, 4'h1);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] val, input logic [7:0] msk);
    expQ.push_back('{val, msk});
    bus(1'b0, adr, 8'h00, 4'h1);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ack[i] <= 1'b1;
    @(posedge clk);
    ack[i] <= 1'b0;
  endtask

  // watcher: each finished read is matched to the oldest note; baud pulses are counted
  always @(posedge clk) begin
    if (read && !waitrequest && expQ.size() > 0) begin
      cmp_reg(readdata, expQ[0].val, expQ[0].msk);
      void'(expQ.pop_front());
    end
    if (baudTick === 1'b1) begin
      nBaud++;
    end
  end

  // gate held low first, then released; the gate pin also freezes the count once irq shows
  task automatic ovf(input int t, input dtc_mode_t m, input logic [7:0] th, input logic [7:0] tl,
                     input logic [7:0] eh, input logic [7:0] el, input logic [7:0] msk);
    logic [7:0] ofs;
    int k;
    ofs = 8'(t * 8);
    k = 0;
    extPin[t] <= 1'b0;
    wr(8'h8C, 8'({2'b10, m}) << (t * 4));
    wr(8'h90 + ofs, tl);
    wr(8'h94 + ofs, th);
    wr(8'hA8, 8'h01 << (t * 2));
    wr(8'h88, 8'h10 << (t * 2));
    repeat (36) @(posedge clk);
    rd(8'h90 + ofs, tl, 8'hFF);
    extPin[t] <= 1'b1;
    while (irq !== 1'b1) begin
      @(posedge clk);
      k++;
      if (k > 100) begin
        n_errors++;
        close_out();
      end
    end
    extPin[t] <= 1'b0;
    rd(8'h88, 8'h30 << (t * 2), 8'hF0);
    pulse(t);
    rd(8'h88, 8'h10 << (t * 2), 8'hF0);
    rd(8'h94 + ofs, eh, 8'hFF);
    rd(8'h90 + ofs, el, msk);
    wr(8'h88, 8'h00);
    wr(8'hA4, 8'h0F);
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(8'h88 + 8'(i * 4), 8'h00, 8'hFF);
    end
    rd(8'h00, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      v = 8'($random(seed));
      wr(8'h8C, v);
      bus(1'b1, 8'h8C, ~v, 4'h0);
      rd(8'h8C, v, 8'hFF);
    end
    for (int t = 0; t < 2; t++) begin
      ovf(t, DTC_M13, 8'hFF, 8'h1E, 8'h00, 8'h00, 8'h1F);
      ovf(t, DTC_M16, 8'hFF, 8'hFE, 8'h00, 8'h00, 8'hFF);
      ovf(t, DTC_M8R, 8'hA5, 8'hFE, 8'hA5, 8'hA5, 8'hFF);
    end
    cmp_out(nBaud, 3);
    // timer 0 split, timer 1 parked in its own mode 3
    extPin <= 2'b11;
    wr(8'h8C, 8'h33);
    wr(8'hA4, 8'h0F);
    wr(8'h90, 8'hFE);
    wr(8'h94, 8'hFF);
    wr(8'h98, 8'hF0);
    wr(8'h88, 8'h50);
    repeat (40) @(posedge clk);
    rd(8'h88, 8'hF0, 8'hF0);
    rd(8'hA0, 8'h05, 8'h0F);
    rd(8'h98, 8'hF0, 8'hFF);
    cmp_out(nBaud, 3);
    pulse(1);
    wr(8'h8C, 8'h23);
    repeat (240) @(posedge clk);
    cmp_out(nBaud, 4);
    rd(8'h88, 8'h70, 8'hF0);
    // external interrupts: edge type, acknowledge, then low level
    wr(8'h88, 8'h05);
    wr(8'hA8, 8'h00);
    wr(8'hA4, 8'h0F);
    extPin <= 2'b00;
    repeat (4) @(posedge clk);
    rd(8'h88, 8'h0F, 8'h0F);
    cmp_out(irq, 0);
    pulse(2);
    pulse(3);
    rd(8'h88, 8'h05, 8'h0F);
    wr(8'h88, 8'h00);
    rd(8'h88, 8'h0A, 8'h0F);
    wr(8'hA8, 8'h0A);
    repeat (3) @(posedge clk);
    cmp_out(irq, 1);
    extPin <= 2'b11;
    repeat (4) @(posedge clk);
    wr(8'hA4, 8'h0F);
    repeat (3) @(posedge clk);
    cmp_out(irq, 0);
    wr(8'h88, 8'hA0);
    pulse(0);
    pulse(1);
    rd(8'h88, 8'h00, 8'hA0);
    // counter mode: timer 0 counts falling edges of its count input only
    wr(8'h8C, 8'h05);
    wr(8'h90, 8'hFE);
    wr(8'h94, 8'hFF);
    wr(8'h88, 8'h10);
    repeat (36) @(posedge clk);
    rd(8'h90, 8'hFE, 8'hFF);
    repeat (2) begin
      cntIn[0] <= 1'b0;
      repeat (24) @(posedge clk);
      cntIn[0] <= 1'b1;
      repeat (24) @(posedge clk);
    end
    rd(8'h94, 8'h00, 8'hFF);
    rd(8'h88, 8'h30, 8'hF0);
    // second reset in mid-run
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    rd(8'h88, 8'h00, 8'hFF);
    close_out();
  end
endmodule
